// ### shared/sgc_defs.svh
// timing constants for the host controller of a 1024 x 4 sram with global clear
// assumes a 20 MHz clock; times in ns, cycle counts derived (least times round up)
`ifndef SGC_DEFS_SVH
`define SGC_DEFS_SVH
`define SGC_CLK_NS 50
`define SGC_ADDR_W 10
`define SGC_DATA_W 4
`define SGC_T_ADDR_SETUP_NS 5
`define SGC_T_DATA_SETUP_NS 10
`define SGC_T_DATA_HOLD_NS 5
`define SGC_T_ADDR_HOLD_NS 5
`define SGC_T_SEL_TO_END_NS 10
`define SGC_T_WR_CYCLE_NS 20
`define SGC_T_CLEAR_PULSE_NS 20
`define SGC_T_CLEAR_ADDR_HOLD_NS 20
`define SGC_T_STROBE_HOLD_CLR_NS 20
`define SGC_T_OUT_RELEASE_NS 15
`define SGC_CYC(ns) (((ns) + `SGC_CLK_NS - 1) / `SGC_CLK_NS)
`define SGC_N_ADDR_SETUP `SGC_CYC(`SGC_T_ADDR_SETUP_NS)
`define SGC_N_WR_PULSE `SGC_CYC(`SGC_T_DATA_SETUP_NS)
`define SGC_N_ADDR_HOLD `SGC_CYC(`SGC_T_ADDR_HOLD_NS)
`define SGC_N_CLEAR_PULSE `SGC_CYC(`SGC_T_CLEAR_PULSE_NS)
`define SGC_N_CLEAR_HOLD `SGC_CYC(`SGC_T_STROBE_HOLD_CLR_NS)
`define SGC_N_OUT_RELEASE `SGC_CYC(`SGC_T_OUT_RELEASE_NS)
`endif

// ### shared/sgc_pkg.sv
// types for the sram host controller
// assumes sgc_defs.svh supplies widths
`include "sgc_defs.svh"
package sgc_pkg;
    typedef enum logic [2:0] {
        SGC_IDLE = 3'b000,
        SGC_WR_SETUP = 3'b001,
        SGC_WR_PULSE = 3'b010,
        SGC_WR_HOLD = 3'b011,
        SGC_RD_WAIT = 3'b100,
        SGC_CLR_PULSE = 3'b101,
        SGC_CLR_HOLD = 3'b110
    } sgc_state_e;
    typedef logic [3:0] sgc_count_t;
endpackage

// ### hdl/sgc_sync.sv
// two flip-flop synchroniser for the read data pins
// assumes pins are asynchronous to clock
`timescale 1ns/10ps
module sgc_sync #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sgc_sync_s;
    sgc_sync_s state_reg;
    sgc_sync_s state_next;
    // ===========================================
    // first stage feeds only the second
    always_comb begin
        state_next = state_reg;
        state_next.stage1 = async_in;
        state_next.stage2 = state_reg.stage1;
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
    assign sync_out = state_reg.stage2;
endmodule

// ### hdl/sgc_host.sv
// host controller driving an asynchronous 1024 x 4 sram with global clear
// assumes the sram pins are wired directly; one request at a time
`timescale 1ns/10ps
`include "sgc_defs.svh"
module sgc_host
    import sgc_pkg::*;
#(
    parameter int ADDR_W = `SGC_ADDR_W,
    parameter int DATA_W = `SGC_DATA_W
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // user request side
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_clear,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    // sram pins
    output logic [ADDR_W-1:0] word_select_lines,
    output logic [DATA_W-1:0] write_word_in,
    input wire logic [DATA_W-1:0] read_word_out,
    output logic select_n,
    output logic store_n,
    output logic out_enable_n,
    output logic clear_n
);
    localparam sgc_count_t N_SETUP = sgc_count_t'(`SGC_N_ADDR_SETUP);
    localparam sgc_count_t N_PULSE = sgc_count_t'(`SGC_N_WR_PULSE);
    localparam sgc_count_t N_HOLD = sgc_count_t'(`SGC_N_ADDR_HOLD);
    localparam sgc_count_t N_CLR = sgc_count_t'(`SGC_N_CLEAR_PULSE);
    localparam sgc_count_t N_CLR_HOLD = sgc_count_t'(`SGC_N_CLEAR_HOLD);
    // read settles after output release time plus two sync stages
    localparam sgc_count_t N_READ = sgc_count_t'(`SGC_N_OUT_RELEASE + 2);

    typedef struct packed {
        sgc_state_e state;
        sgc_count_t count;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic ready;
        logic rsp;
        logic sel_n;
        logic str_n;
        logic oe_n;
        logic clr_n;
    } sgc_host_s;

    sgc_host_s state_reg;
    sgc_host_s state_next;
    logic [DATA_W-1:0] rd_sync;

    // ===========================================
    // read data pins cross into the clock domain
    sgc_sync #(
        .WIDTH(DATA_W)
    ) u_rd_sync (
        .clock(clock),
        .rst_n(rst_n),
        .async_in(read_word_out),
        .sync_out(rd_sync)
    );

    function automatic logic last_cycle(input sgc_count_t c);
        return c <= sgc_count_t'(1);
    endfunction

    // ===========================================
    // sequencer: address and data change only in idle, so each phase gets
    // at least one full 50 ns cycle, above every 5..20 ns figure
    always_comb begin
        state_next = state_reg;
        state_next.rsp = 1'b0;
        state_next.count = (state_reg.count == '0) ? '0 : state_reg.count - sgc_count_t'(1);
        case (state_reg.state)
            SGC_IDLE: begin
                state_next.sel_n = 1'b1;
                state_next.str_n = 1'b1;
                state_next.oe_n = 1'b1;
                state_next.clr_n = 1'b1;
                state_next.ready = 1'b1;
                if (req_valid && state_reg.ready) begin
                    state_next.ready = 1'b0;
                    state_next.addr = req_addr;
                    state_next.wdata = req_wdata;
                    state_next.sel_n = 1'b0;
                    if (req_clear) begin
                        // select low, strobe and enable high before clear falls
                        state_next.state = SGC_CLR_PULSE;
                        state_next.count = N_CLR;
                    end else if (req_write) begin
                        state_next.state = SGC_WR_SETUP;
                        state_next.count = N_SETUP;
                    end else begin
                        state_next.oe_n = 1'b0;
                        state_next.state = SGC_RD_WAIT;
                        state_next.count = N_READ;
                    end
                end
            end
            SGC_WR_SETUP: begin
                if (last_cycle(state_reg.count)) begin
                    state_next.str_n = 1'b0;
                    state_next.state = SGC_WR_PULSE;
                    state_next.count = N_PULSE;
                end
            end
            SGC_WR_PULSE: begin
                if (last_cycle(state_reg.count)) begin
                    // select stayed low through the pulse
                    state_next.str_n = 1'b1;
                    state_next.sel_n = 1'b1;
                    state_next.state = SGC_WR_HOLD;
                    state_next.count = N_HOLD;
                end
            end
            SGC_WR_HOLD: begin
                // address and data kept; return to idle spaces writes apart
                if (last_cycle(state_reg.count)) begin
                    state_next.state = SGC_IDLE;
                    state_next.rsp = 1'b1;
                end
            end
            SGC_RD_WAIT: begin
                if (last_cycle(state_reg.count)) begin
                    state_next.rdata = rd_sync;
                    state_next.rsp = 1'b1;
                    state_next.oe_n = 1'b1;
                    state_next.sel_n = 1'b1;
                    state_next.state = SGC_IDLE;
                end
            end
            SGC_CLR_PULSE: begin
                state_next.clr_n = 1'b0;
                if (state_reg.clr_n == 1'b1) begin
                    // pulse count starts when clear really falls, not in the settle cycle
                    state_next.count = N_CLR;
                end else if (last_cycle(state_reg.count)) begin
                    state_next.clr_n = 1'b1;
                    state_next.state = SGC_CLR_HOLD;
                    state_next.count = N_CLR_HOLD;
                end
            end
            SGC_CLR_HOLD: begin
                // strobe high and address steady after clear returns
                if (last_cycle(state_reg.count)) begin
                    state_next.sel_n = 1'b1;
                    state_next.rsp = 1'b1;
                    state_next.state = SGC_IDLE;
                end
            end
            default: begin
                state_next.state = SGC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg <= '{state: SGC_IDLE, count: '0, addr: '0, wdata: '0, rdata: '0,
                ready: 1'b0, rsp: 1'b0, sel_n: 1'b1, str_n: 1'b1, oe_n: 1'b1, clr_n: 1'b1};
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state register
    assign req_ready = state_reg.ready;
    assign rsp_valid = state_reg.rsp;
    assign rsp_rdata = state_reg.rdata;
    assign word_select_lines = state_reg.addr;
    assign write_word_in = state_reg.wdata;
    assign select_n = state_reg.sel_n;
    assign store_n = state_reg.str_n;
    assign out_enable_n = state_reg.oe_n;
    assign clear_n = state_reg.clr_n;

    // ===========================================
    // checks on the pin sequences
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence clr_low_run;
        (!clear_n && !select_n) [*1];
    endsequence
    // clear returns high while select is still held low and strobe high
    sequence clr_release;
        clear_n && !select_n && store_n;
    endsequence

    write_gating_a: assert property (!store_n |-> clear_n && !select_n)
        else $error("strobe low without select or with clear");
    data_stable_a: assert property ($rose(store_n) |-> $stable(write_word_in))
        else $error("data changed at end of write");
    addr_setup_a: assert property ($fell(store_n) |-> $stable(word_select_lines))
        else $error("address moved at write start");
    addr_hold_a: assert property ($rose(store_n) |=> $stable(word_select_lines))
        else $error("address moved after write");
    sel_before_end_a: assert property ($rose(store_n) |-> $past(!select_n, 2))
        else $error("select not low before strobe rose");
    read_ctrl_a: assert property (!out_enable_n |-> store_n && clear_n)
        else $error("read with strobe or clear low");
    clr_width_a: assert property ($fell(clear_n) |-> clr_low_run ##1 clr_release)
        else $error("clear pulse too short");
    clr_ctrl_a: assert property (!clear_n |-> !select_n && store_n && out_enable_n)
        else $error("controls wrong during clear");
    clr_addr_a: assert property ($rose(clear_n) |=> $stable(word_select_lines) && store_n)
        else $error("address or strobe moved after clear");
    clr_recover_a: assert property ($rose(clear_n) |-> store_n [*2])
        else $error("write too soon after clear");
endmodule

// ### testbench/sgc_sram_model.sv
// sram model: 1024 x 4 words with global clear, seen from its pins
// assumes the host drives every pin; counts host timing faults
`timescale 1ns/10ps
module sgc_sram_model (
    // pins from the host
    input wire logic [9:0] word_select_lines,
    input wire logic [3:0] write_word_in,
    input wire logic select_n,
    input wire logic store_n,
    input wire logic out_enable_n,
    input wire logic clear_n,
    // pins to the host, fault count
    output logic [3:0] read_word_out,
    output int timing_faults
);
    // ====================
    // storage and timing marks
    logic [3:0] mem [0:1023];
    logic [3:0] q;
    logic [3:0] held = 4'h5;
    logic armed = 0;
    logic in_clr = 0;
    realtime ta = -100, td = -100, ts = -100, te = -100, tf = -100, tr = -100;
    wire wr_act = !select_n && !store_n && clear_n;
    wire drive = !select_n && store_n && !out_enable_n && clear_n;
    // stale nonzero contents so that a clear shows
    initial begin
        timing_faults = 0;
        for (int i = 0; i < 1024; i++) mem[i] = 4'ha;
    end
    // ====================
    // host timing checks
    always @(word_select_lines) begin
        if ($realtime - ta < 20 || $realtime - te < 5 || in_clr || $realtime - tr < 20)
            timing_faults++;
        ta = $realtime;
    end
    always @(write_word_in) begin
        if ($realtime - te < 5 || wr_act) timing_faults++;
        td = $realtime;
    end
    always @(negedge select_n) ts = $realtime;
    always @(posedge wr_act) begin
        if ($realtime - ta < 5 || $realtime - tr < 20) timing_faults++;
        armed = 1;
    end
    // data is taken when either strobe ends the write
    always @(negedge wr_act) if (armed) begin
        if ($realtime - td < 10 || $realtime - ts < 10) timing_faults++;
        mem[word_select_lines] = write_word_in;
        armed = 0;
        te = $realtime;
    end
    // ====================
    // global clear, applied when clear returns high at the end of the pulse
    always @(negedge clear_n) begin
        if (select_n !== 1'b0 || store_n !== 1'b1) timing_faults++;
        tf = $realtime;
        in_clr = 1;
    end
    always @(posedge clear_n) if (in_clr) begin
        if ($realtime - tf < 20 || select_n !== 1'b0) timing_faults++;
        for (int i = 0; i < 1024; i++) mem[i] = 4'h0;
        in_clr = 0;
        tr = $realtime;
    end
    // ====================
    // read path; a released bus shows the inverse of the last word
    always @* q = drive ? mem[word_select_lines] : ~held;
    always @(q) if (drive) held = q;
    assign #3 read_word_out = q;
endmodule

// ### testbench/tb_top.sv
// bench for the sram host controller with the sram model on its pins
// assumes the model counts host timing faults; 20 MHz clock
`timescale 1ns/10ps
`include "sgc_defs.svh"
module tb_top;
    // answer latency in clock edges after the take, from the phase counts
    localparam int LAT_WR = `SGC_N_ADDR_SETUP + `SGC_N_WR_PULSE + `SGC_N_ADDR_HOLD;
    localparam int LAT_RD = `SGC_N_OUT_RELEASE + 2;
    // one settle cycle with select low comes before clear falls
    localparam int LAT_CLR = 1 + `SGC_N_CLEAR_PULSE + `SGC_N_CLEAR_HOLD;
    // ====================
    // signals
    logic clock = 0;
    logic rst_n = 0;
    logic req_valid = 0;
    logic req_write = 0;
    logic req_clear = 0;
    logic [9:0] req_addr = 10'h000;
    logic [3:0] req_wdata = 4'h0;
    logic req_ready, rsp_valid, select_n, store_n, out_enable_n, clear_n;
    logic [3:0] rsp_rdata, write_word_in, read_word_out;
    logic [9:0] word_select_lines;
    int timing_faults;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    sgc_host i_dut (.clock, .rst_n, .req_valid, .req_write, .req_clear, .req_addr,
        .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .word_select_lines,
        .write_word_in, .read_word_out, .select_n, .store_n, .out_enable_n, .clear_n);
    sgc_sram_model i_mem (.word_select_lines, .write_word_in, .select_n, .store_n,
        .out_enable_n, .clear_n, .read_word_out, .timing_faults);
    initial begin
        forever #25 clock = ~clock;
    end
    // ====================
    // checking and closing
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // a hang counts as a mismatch
    always @(posedge clock) begin
        cycles++;
        if (cycles >= 2000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    // one request: wait for ready, hand it over, count edges to the answer
    task automatic op(input logic c, input logic w, input logic [9:0] a, input logic [3:0] d,
        input int lat, output logic [3:0] q);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 40) begin
            @(posedge clock);
            #2 n++;
        end
        {req_valid, req_clear, req_write, req_addr, req_wdata} = {1'b1, c, w, a, d};
        @(posedge clock);
        #2 req_valid = 0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 40) begin
            @(posedge clock);
            #2 n++;
        end
        check("answer latency", n, lat);
        q = rsp_rdata;
    endtask
    // ====================
    // scenarios
    task automatic edge_words();
        logic [3:0] q;
        op(0, 1, 10'h000, 4'h3, LAT_WR, q);
        op(0, 1, 10'h3ff, 4'hc, LAT_WR, q);
        op(0, 0, 10'h000, 4'h0, LAT_RD, q);
        check("low word", q, 4'h3);
        op(0, 0, 10'h3ff, 4'h0, LAT_RD, q);
        check("top word", q, 4'hc);
    endtask
    // back-to-back writes to one word: the second must win
    task automatic overwrite();
        logic [3:0] q;
        op(0, 1, 10'h155, 4'h9, LAT_WR, q);
        op(0, 1, 10'h155, 4'h6, LAT_WR, q);
        op(0, 0, 10'h155, 4'h0, LAT_RD, q);
        check("overwritten word", q, 4'h6);
    endtask
    // clear with the write flag also set, then five reads, then a write
    task automatic clear_all();
        logic [9:0] at[5] = '{10'h000, 10'h3ff, 10'h155, 10'h2aa, 10'h0a5};
        logic [3:0] q;
        op(1, 1, 10'h2aa, 4'hf, LAT_CLR, q);
        foreach (at[i]) begin
            op(0, 0, at[i], 4'h0, LAT_RD, q);
            check("cleared word", q, 4'h0);
        end
        op(0, 1, 10'h2aa, 4'h7, LAT_WR, q);
        op(0, 0, 10'h2aa, 4'h0, LAT_RD, q);
        check("write after clear", q, 4'h7);
    endtask
    // ====================
    // main sequence
    initial begin
        repeat (12) @(posedge clock);
        #2;
        check("idle controls", {select_n, store_n, out_enable_n, clear_n}, 4'hf);
        check("ready in reset", req_ready, 1'b0);
        rst_n = 1;
        edge_words();
        overwrite();
        clear_all();
        check("timing faults", timing_faults, 0);
        tally_and_finish();
    end
endmodule
